// ===== src/sleep_wake_pin_control.v
// Functional notes
// - Awake indicator low asleep, high awake.
// - CTS driven high on entering sleep.
// - CTS driven low on waking.
// - Ignore serial and radio data while asleep.
// - UART pin sleep only with sleep-request pin.
// - SPI asserts attention after init with status.
// - Attention follows pending data while awake.
// - SPI uses sleep pin if configured, else chip-select.
// - Chip-select negation sleeps the device.
// - Pin sleep and cyclic sleep modes supported.
// - Option keeps association or deep sleeps.
// - Cyclic wake checks 30 ms, resleeps if idle.
// - Chip-select assertion wakes the device unless the sleep pin is configured.
`timescale 1ns/100ps
`default_nettype none
`include "sleep_wake_map.vh"

module sleep_wake_pin_control
(
    input wire core_clk,
    input wire rstn,
    input wire spiMode, // High selects the SPI host interface.
    input wire [2:0] cts_pin_config,
    input wire [2:0] sleep_pin_config,
    input wire [2:0] awake_pin_config,
    input wire [1:0] sleep_mode_select,
    input wire sleepOption, // Associated or deep sleep.
    input wire [31:0] sleepPeriod, // Cyclic sleep time in cycles.
    input wire [31:0] stayAwakeTime, // Cyclic wake time in cycles.
    input wire initDone, // Pulse or level: device initialisation done.
    input wire dataPending, // Device has data for the SPI master.
    input wire traffic, // Serial or radio activity this cycle.
    input wire associated, // Radio is associated with the access point.
    input wire sleep_request_pin,
    input wire spi_chip_select_n,
    input wire serialRxValid, // Incoming serial byte strobe.
    input wire radioRxValid, // Incoming radio frame strobe.
    output reg awake_indicator,
    output reg ctsN,
    output reg spi_attention_n,
    output reg statusMsgStrobe, // One-cycle request for a status message.
    output reg serialRxAccept, // Gated serial strobe.
    output reg radioRxAccept, // Gated radio strobe.
    output reg radioPowerOn, // Radio circuitry powered.
    output reg reassociateReq // One-cycle request to associate on wake.
);

    ////////////////////////////////////////////////////////////////////
    // State encoding, one-hot.
    localparam [3:0] ST_AWAKE = 4'b0001;
    localparam [3:0] ST_SLEEP = 4'b0010;
    localparam [3:0] ST_CHECK = 4'b0100;
    localparam [3:0] ST_STAY = 4'b1000;

    localparam [31:0] CHECK_CYC = `WAKE_CHECK_CYCLES;

    reg [3:0] state_r; // Sleep sequencer state.
    reg [3:0] state_nxt; // Next state.
    reg [31:0] timer_r; // Period counter for cyclic sleep.
    reg [31:0] timer_nxt; // Next counter value.
    reg sawTraffic_r; // Activity seen in the check window.
    reg sawTraffic_nxt; // Next activity flag.
    reg initSeen_r; // Initialisation completion has been announced.
    wire sleepReqSync; // Synchronised sleep request, high asks for sleep.
    wire csSync; // Synchronised chip-select, high means negated.

    ////////////////////////////////////////////////////////////////////
    // Both pins are synchronised before any decision uses them.
    level_sync syncReq
    (
        .core_clk(core_clk),
        .rstn(rstn),
        .resetLevel(1'b0),
        .din(sleep_request_pin),
        .dout(sleepReqSync)
    );

    level_sync syncCs
    (
        .core_clk(core_clk),
        .rstn(rstn),
        .resetLevel(1'b0),
        .din(spi_chip_select_n),
        .dout(csSync)
    );

    ////////////////////////////////////////////////////////////////////
    // Pin selection and sleep demand.
    wire sleepPinSel = (sleep_pin_config == `PIN_CFG_PERIPHERAL);
    wire pinMode = (sleep_mode_select == `SLEEP_MODE_PIN);
    wire cycMode = (sleep_mode_select == `SLEEP_MODE_CYCLIC);
    // Without the sleep pin on UART there is no pin sleep at all.
    // On SPI the sleep pin wins when selected, else chip-select.
    wire pinSleepSrc = sleepPinSel ? sleepReqSync :
                       (spiMode ? csSync : 1'b0);
    wire pinWantsSleep = pinMode & pinSleepSrc;
    wire asleep = (state_r == ST_SLEEP);

    ////////////////////////////////////////////////////////////////////
    // Next-state logic for pin and cyclic sleep.
    always @*
    begin
        state_nxt = state_r;
        timer_nxt = timer_r;
        sawTraffic_nxt = sawTraffic_r;
        case (state_r)
            ST_AWAKE:
            begin
                // A level change gives one transition only.
                if (pinWantsSleep)
                    state_nxt = ST_SLEEP;
                else if (cycMode)
                begin
                    state_nxt = ST_SLEEP;
                    timer_nxt = sleepPeriod;
                end
            end
            ST_SLEEP:
            begin
                if (pinMode)
                begin
                    // Releasing the request or asserting chip-select.
                    if (!pinSleepSrc)
                        state_nxt = ST_AWAKE;
                end
                else if (cycMode)
                begin
                    if (timer_r <= 32'h0000_0001)
                    begin
                        state_nxt = ST_CHECK;
                        timer_nxt = CHECK_CYC;
                        sawTraffic_nxt = 1'b0;
                    end
                    else
                        timer_nxt = timer_r - 32'h0000_0001;
                end
                else
                    state_nxt = ST_AWAKE;
            end
            ST_CHECK:
            begin
                // Short window; traffic extends to the stay time.
                if (traffic)
                    sawTraffic_nxt = 1'b1;
                if (!cycMode)
                    state_nxt = ST_AWAKE;
                else if (timer_r <= 32'h0000_0001)
                begin
                    if (sawTraffic_r | traffic)
                    begin
                        state_nxt = ST_STAY;
                        timer_nxt = (stayAwakeTime > CHECK_CYC) ?
                            stayAwakeTime - CHECK_CYC : 32'h0000_0001;
                    end
                    else
                    begin
                        state_nxt = ST_SLEEP;
                        timer_nxt = sleepPeriod;
                    end
                end
                else
                    timer_nxt = timer_r - 32'h0000_0001;
            end
            ST_STAY:
            begin
                // Further activity does not restart the stay time.
                if (!cycMode)
                    state_nxt = ST_AWAKE;
                else if (timer_r <= 32'h0000_0001)
                begin
                    state_nxt = ST_SLEEP;
                    timer_nxt = sleepPeriod;
                end
                else
                    timer_nxt = timer_r - 32'h0000_0001;
            end
            default:
                state_nxt = ST_AWAKE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // State registers.
    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= ST_AWAKE;
            timer_r <= 32'h0000_0000;
            sawTraffic_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
            sawTraffic_r <= sawTraffic_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registered pin outputs and strobes.
    wire sleepNext = (state_nxt == ST_SLEEP);
    wire wakeEdge = asleep & ~sleepNext;

    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            awake_indicator <= 1'b1;
            ctsN <= 1'b0;
            spi_attention_n <= 1'b1;
            statusMsgStrobe <= 1'b0;
            serialRxAccept <= 1'b0;
            radioRxAccept <= 1'b0;
            radioPowerOn <= 1'b1;
            reassociateReq <= 1'b0;
            initSeen_r <= 1'b0;
        end
        else
        begin
            // Only driven as indicator when the pin has that function.
            awake_indicator <= (awake_pin_config == `PIN_CFG_PERIPHERAL)
                ? ~sleepNext : 1'b0;
            // CTS high while asleep, low once awake.
            ctsN <= (cts_pin_config == `CTS_CFG_FLOW) ? sleepNext : 1'b0;
            // Data is dropped while asleep.
            serialRxAccept <= serialRxValid & ~asleep;
            radioRxAccept <= radioRxValid & ~asleep;
            // Deep sleep powers the radio down; associated keeps it.
            radioPowerOn <= ~(sleepNext & (sleepOption == `SLEEP_OPT_DEEP));
            reassociateReq <= wakeEdge &
                ((sleepOption == `SLEEP_OPT_DEEP) | ~associated);
            // First ready report after initialisation on SPI.
            statusMsgStrobe <= spiMode & initDone & ~initSeen_r;
            if (spiMode & initDone)
                initSeen_r <= 1'b1;
            // Attention follows pending data while awake.
            if (!spiMode)
                spi_attention_n <= 1'b1;
            else if (initDone & ~initSeen_r)
                spi_attention_n <= 1'b0;
            else if (initSeen_r & ~sleepNext)
                spi_attention_n <= ~dataPending;
        end
    end

endmodule

`default_nettype wire

// ===== src/sleep_wake_map.vh
`ifndef SLEEP_WAKE_MAP_VH
`define SLEEP_WAKE_MAP_VH

// Pin function code for the sleep-request and awake pins.
`define PIN_CFG_PERIPHERAL 3'h1
// CTS pin code that enables hardware flow control.
`define CTS_CFG_FLOW 3'h1

// Sleep mode selections.
`define SLEEP_MODE_NONE 2'h0
`define SLEEP_MODE_PIN 2'h1
`define SLEEP_MODE_CYCLIC 2'h2

// Sleep option: 0 stays associated, 1 is deep sleep.
`define SLEEP_OPT_ASSOC 1'h0
`define SLEEP_OPT_DEEP 1'h1

// Clock rate in kHz and the cyclic wake check window in ms.
`define CLK_KHZ 32'h0000_61A8
`define WAKE_CHECK_MS 32'h0000_001E
`define WAKE_CHECK_CYCLES (`WAKE_CHECK_MS * `CLK_KHZ)

// Width of the sleep and wake period counters.
`define PERIOD_W 32

`endif

// ===== src/level_sync.v
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser; the first stage feeds only the second.
module level_sync
(
    input wire core_clk,
    input wire rstn,
    input wire resetLevel,
    input wire din,
    output reg dout
);

    reg meta_r; // First stage, read only by the second stage.

    // The resetLevel input flips the sense of the pin when set. Both stages
    // clear on reset, so the output starts at the no-request level and the
    // device leaves reset awake instead of acting on a false request.
    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_r <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            meta_r <= din ^ resetLevel;
            dout <= meta_r;
        end
    end

endmodule

`default_nettype wire

// ===== tb/host_mcu.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Host side: pin-controlled sleep and CTS-gated serial sends.
module host_mcu
(
    input wire logic cmdSleep, // Host wants the device asleep.
    input wire logic useCs, // Chip-select carries the sleep request.
    input wire logic txReq, // Host has a serial byte to send.
    input wire logic rude, // Ignore CTS, used only to probe gating.
    input wire logic ctsN,
    output logic sleep_request_pin,
    output logic spi_chip_select_n,
    output logic serialRxValid
);
    // High asks for sleep, low wakes the device.
    assign sleep_request_pin = useCs ? 1'b0 : cmdSleep;
    // Negated select doubles as the sleep request.
    assign spi_chip_select_n = useCs ? cmdSleep : 1'b0;
    // A polite host holds data while CTS is high.
    assign serialRxValid = txReq & (rude | ~ctsN);
endmodule
`default_nettype wire

// ===== tb/sleep_wake_pin_control_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "sleep_wake_map.vh"
////////////////////////////////////////////////////////////////////////
module sleep_wake_pin_control_assertions
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic spiMode,
    input wire logic [2:0] sleep_pin_config,
    input wire logic [1:0] sleep_mode_select,
    input wire logic sleepOption,
    input wire logic initDone,
    input wire logic sleep_request_pin,
    input wire logic spi_chip_select_n,
    input wire logic serialRxValid,
    input wire logic awake_indicator,
    input wire logic ctsN,
    input wire logic spi_attention_n,
    input wire logic statusMsgStrobe,
    input wire logic serialRxAccept,
    input wire logic radioPowerOn
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Which pin currently owns pin sleep.
    wire pinMode = sleep_mode_select == `SLEEP_MODE_PIN;
    wire rqOwns = pinMode && sleep_pin_config == 3'h1;
    wire csOwns = pinMode && spiMode && sleep_pin_config != 3'h1;
    // Six steady samples cover the two sync stages plus margin.
    sequence rqHigh; (rqOwns && sleep_request_pin)[*6]; endsequence
    sequence rqLow; (rqOwns && !sleep_request_pin)[*6]; endsequence
    sequence rxAsleep; serialRxValid && !awake_indicator ##1
        !awake_indicator; endsequence
    sequence rxAwake; serialRxValid && awake_indicator ##1
        awake_indicator; endsequence
    a_rq_sleeps: assert property (rqHigh |-> !awake_indicator)
        else $error("indicator high while asleep");
    a_rq_wakes: assert property (rqLow |-> awake_indicator)
        else $error("indicator low while awake");
    a_cts_sleep: assert property (rqHigh |-> ctsN)
        else $error("cts low while asleep");
    a_cts_wake: assert property (rqLow |-> !ctsN)
        else $error("cts high while awake");
    a_uart_nosleep: assert property ((pinMode && !spiMode
        && sleep_pin_config != 3'h1)[*6] |-> awake_indicator)
        else $error("uart slept without sleep pin");
    a_rx_gated: assert property (rxAsleep |-> !serialRxAccept)
        else $error("serial byte taken while asleep");
    a_rx_passed: assert property (rxAwake |-> serialRxAccept)
        else $error("serial byte lost while awake");
    a_cs_sleeps: assert property ((csOwns && spi_chip_select_n)[*6]
        |-> !awake_indicator)
        else $error("negated select did not sleep");
    a_cs_wakes: assert property ((csOwns && !spi_chip_select_n)[*6]
        |-> awake_indicator)
        else $error("asserted select did not wake");
    a_status_sent: assert property (spiMode && $rose(initDone)
        |-> ##[1:6] statusMsgStrobe)
        else $error("no status message after init");
    a_attn_ready: assert property (statusMsgStrobe |-> !spi_attention_n)
        else $error("attention high at status message");
    a_deep_power: assert property ((sleepOption && !awake_indicator)[*2]
        |-> !radioPowerOn)
        else $error("radio powered in deep sleep");
endmodule
bind sleep_wake_pin_control sleep_wake_pin_control_assertions chk
(
    .core_clk(core_clk), .rstn(rstn), .spiMode(spiMode),
    .sleep_pin_config(sleep_pin_config),
    .sleep_mode_select(sleep_mode_select), .sleepOption(sleepOption),
    .initDone(initDone), .sleep_request_pin(sleep_request_pin),
    .spi_chip_select_n(spi_chip_select_n), .serialRxValid(serialRxValid),
    .awake_indicator(awake_indicator), .ctsN(ctsN),
    .spi_attention_n(spi_attention_n),
    .statusMsgStrobe(statusMsgStrobe), .serialRxAccept(serialRxAccept),
    .radioPowerOn(radioPowerOn)
);
`default_nettype wire

// ===== tb/sleep_wake_pin_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "sleep_wake_map.vh"
////////////////////////////////////////////////////////////////////////
module sleep_wake_pin_control_tb;
    reg core_clk = 0, rstn = 0, spiMode = 0, sleepOption = 0;
    reg initDone = 0, dataPending = 0, associated = 1, radioRxValid = 0;
    reg cmdSleep = 0, useCs = 0, txReq = 0, rude = 0, statusSeen = 0;
    reg traffic = 0, reassocSeen = 0;
    reg [1:0] sleepMode = `SLEEP_MODE_PIN; // Pin sleep to start with.
    reg [2:0] sleepCfg = 3'h1; // Sleep-request pin function selected.
    wire sleepPin, csN, serRx, awake, ctsN, attnN, statusMsg;
    wire serAcc, radAcc, radioPwr, reassoc;
    int miscompares = 0, num_checks = 0, cycles = 0;
    sleep_wake_pin_control DUT (.core_clk(core_clk), .rstn(rstn),
        .spiMode(spiMode), .cts_pin_config(3'h1),
        .sleep_pin_config(sleepCfg), .awake_pin_config(3'h1),
        .sleep_mode_select(sleepMode), .sleepOption(sleepOption),
        .sleepPeriod(32'h0000_0100), .stayAwakeTime(32'h0000_0100),
        .initDone(initDone), .dataPending(dataPending), .traffic(traffic),
        .associated(associated), .sleep_request_pin(sleepPin),
        .spi_chip_select_n(csN), .serialRxValid(serRx),
        .radioRxValid(radioRxValid), .awake_indicator(awake),
        .ctsN(ctsN), .spi_attention_n(attnN),
        .statusMsgStrobe(statusMsg), .serialRxAccept(serAcc),
        .radioRxAccept(radAcc), .radioPowerOn(radioPwr),
        .reassociateReq(reassoc));
    host_mcu host (.cmdSleep(cmdSleep), .useCs(useCs), .txReq(txReq),
        .rude(rude), .ctsN(ctsN), .sleep_request_pin(sleepPin),
        .spi_chip_select_n(csN), .serialRxValid(serRx));
    // 25 MHz clock.
    initial forever #20 core_clk = ~core_clk;
    // The status strobe lasts one cycle, so it is latched here.
    always @(posedge core_clk) if (statusMsg) statusSeen <= 1'b1;
    // The reassociation request is a one-cycle pulse as well.
    always @(posedge core_clk) if (reassoc) reassocSeen <= 1'b1;
    task chk(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %b expected %b", $time, got, exp);
        end
    endtask
    // Outputs read at the edge still hold their settled values.
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Whole run is under 500 cycles, so 3000 means a hang.
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            $display("[ERR] %0t run timed out", $time);
            wrap_up();
        end
    end
    initial
    begin
        tick(8);
        rstn <= 1;
        tick(2);
        chk(awake, 1);
        radioRxValid <= 1;
        tick(1);
        radioRxValid <= 0;
        tick(1);
        chk(radAcc, 1);
        cmdSleep <= 1;
        tick(8);
        chk(awake, 0);
        chk(ctsN, 1);
        chk(radioPwr, 1);
        rude <= 1;
        txReq <= 1;
        radioRxValid <= 1;
        tick(1);
        txReq <= 0;
        radioRxValid <= 0;
        tick(1);
        chk(serAcc, 0);
        chk(radAcc, 0);
        cmdSleep <= 0;
        tick(8);
        chk(awake, 1);
        chk(ctsN, 0);
        rude <= 0;
        txReq <= 1;
        tick(1);
        txReq <= 0;
        tick(1);
        chk(serAcc, 1);
        sleepCfg <= 3'h0;
        cmdSleep <= 1;
        tick(8);
        chk(awake, 1);
        chk(reassocSeen, 0);
        sleepCfg <= 3'h1;
        sleepOption <= 1;
        associated <= 0;
        tick(8);
        chk(radioPwr, 0);
        cmdSleep <= 0;
        tick(8);
        chk(radioPwr, 1);
        chk(reassocSeen, 1);
        sleepOption <= 0;
        associated <= 1;
        spiMode <= 1;
        sleepCfg <= 3'h0;
        useCs <= 1;
        initDone <= 1;
        tick(8);
        chk(statusSeen, 1);
        dataPending <= 1;
        tick(6);
        chk(attnN, 0);
        dataPending <= 0;
        tick(2);
        chk(attnN, 1);
        cmdSleep <= 1;
        tick(8);
        chk(awake, 0);
        cmdSleep <= 0;
        tick(8);
        chk(awake, 1);
        sleepCfg <= 3'h1;
        useCs <= 0;
        cmdSleep <= 1;
        tick(8);
        chk(awake, 0);
        cmdSleep <= 0;
        tick(8);
        chk(awake, 1);
        // Cyclic sleep: the indicator falls one edge after the mode change
        // and rises after sleepPeriod (256) cycles of sleep.
        sleepMode <= `SLEEP_MODE_CYCLIC;
        tick(2);
        chk(awake, 0);
        chk(ctsN, 1);
        chk(radioPwr, 1);
        tick(255);
        chk(awake, 0);
        tick(1);
        chk(awake, 1);
        chk(ctsN, 0);
        // Activity in the check window must not end it early.
        traffic <= 1;
        tick(1);
        traffic <= 0;
        tick(1);
        chk(awake, 1);
        // Mode none never sleeps, even with the request pin high.
        sleepMode <= `SLEEP_MODE_NONE;
        cmdSleep <= 1;
        tick(8);
        chk(awake, 1);
        wrap_up();
    end
endmodule
`default_nettype wire
